/* common/acr_map.vh */
// Purpose: constants for the converter clock, rate and reset block
// Assumes: 32-bit AXI4-Lite register bus, byte addresses
// Notes:   definitions only
`ifndef ACR_MAP_VH
`define ACR_MAP_VH

// ****************************************
// Register byte offsets
// ****************************************
`define ACR_OFF_CONFIG      12'h000
`define ACR_OFF_STATUS      12'h004
`define ACR_OFF_IRQ_STAT    12'h008
`define ACR_OFF_IRQ_MASK    12'h00c
`define ACR_OFF_SAMPLE      12'h010
`define ACR_OFF_RESULT      12'h014
`define ACR_OFF_TRIM_BASE   12'h040
`define ACR_OFF_TRIM_LAST   12'h06c
`define ACR_TRIM_CH_LSB     3
`define ACR_TRIM_CH_MSB     5

// ****************************************
// Fields of primary_config_word
// ****************************************
`define ACR_CFG_OSR_LSB     0
`define ACR_CFG_OSR_MSB     2
`define ACR_CFG_PRE_LSB     4
`define ACR_CFG_PRE_MSB     5
`define ACR_CFG_EXT_BIT     8
`define ACR_CFG_CHAN_LSB    12
`define ACR_CFG_CHAN_MSB    14
`define ACR_CFG_RESET       32'h0000_0003

// ****************************************
// Interrupt bits
// ****************************************
`define ACR_IRQ_DONE        0
`define ACR_IRQ_SAMPLE      1
`define ACR_IRQ_W           2

// ****************************************
// Divider, trim width and bus response constants
// ****************************************
`define ACR_SAMPLE_DIV      3'h4
`define ACR_OSR_MIN_LOG2    5
`define ACR_TRIM_W          24
`define ACR_RESP_OKAY       2'h0
`define ACR_RESP_SLVERR     2'h2

`endif

/* core/acr_clk_mux.v */
// Purpose: master clock source selection, crystal or clock pin
// Assumes: both sources are sampled in the aclk domain
// Notes:   pin passes two flip-flops before selection
`timescale 1ns/1ps
`default_nettype none

module acr_clk_mux (
    input  wire aclk,
    input  wire aresetn,
    input  wire crystal_clk,
    input  wire crystal_or_clock_pin,
    input  wire external_clock_select,
    output reg  master_clk_ff
);

    reg xtal_s1_ff;
    reg xtal_s2_ff;
    reg pin_s1_ff;
    reg pin_s2_ff;

    // Synchronisers; first stage read only by second stage
    always @(posedge aclk) begin
        if (!aresetn) begin
            xtal_s1_ff <= 1'b0;
            xtal_s2_ff <= 1'b0;
            pin_s1_ff  <= 1'b0;
            pin_s2_ff  <= 1'b0;
        end else begin
            xtal_s1_ff <= crystal_clk;
            xtal_s2_ff <= xtal_s1_ff;
            pin_s1_ff  <= crystal_or_clock_pin;
            pin_s2_ff  <= pin_s1_ff;
        end
    end

    // Source select; the input stage keeps sampling through hard reset, but aresetn clears it
    always @(posedge aclk) begin
        if (!aresetn) begin
            master_clk_ff <= 1'b0;
        end else begin
            master_clk_ff <= external_clock_select ? pin_s2_ff : xtal_s2_ff;
        end
    end

endmodule

`default_nettype wire

/* core/acr_trim.v */
// Purpose: per-channel offset and gain correction of one result
// Assumes: signed 24-bit sample and trims, gain in 1.23 format
// Notes:   combinational, registered by the caller
`timescale 1ns/1ps
`default_nettype none

module acr_trim #(
    parameter W = 24
) (
    input  wire [W-1:0] sample,
    input  wire [W-1:0] offset_trim,
    input  wire [W-1:0] gain_trim,
    output wire [W-1:0] corrected
);

    wire signed [W:0]     sum;
    wire signed [2*W:0]   prod;

    // Offset first, then gain of one plus trim; saturation omitted for area
    assign sum  = $signed({sample[W-1], sample}) + $signed({offset_trim[W-1], offset_trim});
    assign prod = sum * $signed({gain_trim[W-1], gain_trim});
    assign corrected = sum[W-1:0] + prod[2*W-2:W-1];

endmodule

`default_nettype wire

/* core/acr_top.v */
// Purpose: clock derivation, data rate strobe and hard reset for six channels
// Assumes: aclk at 40 MHz is much faster than the master clock
// Notes:   registers over AXI4-Lite; divided clocks are enables
//
// The register addresses and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "acr_map.vh"

module acr_top #(
    parameter NCH = 6
) (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire        hard_reset_n,
    input  wire        crystal_clk,
    input  wire        crystal_or_clock_pin,
    input  wire [23:0] modulator_sample,
    output reg         conversion_done_strobe_n_ff,
    output reg  [23:0] result_ff,
    output wire        analog_clock,
    output wire        irq,
    input  wire [11:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [11:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready
);

    // ****************************************
    // Functions
    // ****************************************
    // Decimation ratio minus one from the three-bit field
    function [11:0] osr_last;
        input [2:0] code;
        begin
            osr_last = (12'h001 << (code + `ACR_OSR_MIN_LOG2)) - 12'h001;
        end
    endfunction

    // Byte-lane merge honouring write strobes
    function [31:0] wmerge;
        input [31:0] old;
        input [31:0] dat;
        input [3:0]  stb;
        integer i;
        begin
            wmerge = old;
            for (i = 0; i < 4; i = i + 1) begin
                if (stb[i]) begin
                    wmerge[i*8 +: 8] = dat[i*8 +: 8];
                end
            end
        end
    endfunction

    // Channel of a trim address; channel pairs sit eight bytes apart
    function [2:0] trim_chan;
        input [11:0] addr;
        begin
            trim_chan = addr[`ACR_TRIM_CH_MSB:`ACR_TRIM_CH_LSB];
        end
    endfunction

    // ****************************************
    // Hard reset pin synchroniser
    // ****************************************
    reg  hrst_s1_ff;
    reg  hrst_s2_ff;
    wire rst_n;

    always @(posedge aclk) begin
        if (!aresetn) begin
            hrst_s1_ff <= 1'b0;
            hrst_s2_ff <= 1'b0;
        end else begin
            hrst_s1_ff <= hard_reset_n;
            hrst_s2_ff <= hrst_s1_ff;
        end
    end

    // Either reset gives the power-on state, except the input synchronisers, master_clk_ff and mclk_d_ff, which only aresetn clears
    assign rst_n = aresetn & hrst_s2_ff;

    // ****************************************
    // Registers
    // ****************************************
    reg [31:0]  config_ff;
    reg [2:0]   irq_stat_ff;
    reg [2:0]   irq_mask_ff;
    reg [23:0]  channel_offset_trim [0:NCH-1];
    reg [23:0]  channel_gain_trim   [0:NCH-1];

    wire [2:0]  oversampling_field;
    wire [1:0]  prescale_sel;
    wire        external_clock_select;
    wire [2:0]  chan_sel;

    assign oversampling_field    = config_ff[`ACR_CFG_OSR_MSB:`ACR_CFG_OSR_LSB];
    assign prescale_sel          = config_ff[`ACR_CFG_PRE_MSB:`ACR_CFG_PRE_LSB];
    assign external_clock_select = config_ff[`ACR_CFG_EXT_BIT];
    assign chan_sel              = config_ff[`ACR_CFG_CHAN_MSB:`ACR_CFG_CHAN_LSB];

    // ****************************************
    // Master clock and its edge
    // ****************************************
    wire master_clk;
    reg  mclk_d_ff;
    wire mclk_rise;

    acr_clk_mux u_mux (
        .aclk                  (aclk),
        .aresetn               (aresetn),
        .crystal_clk           (crystal_clk),
        .crystal_or_clock_pin  (crystal_or_clock_pin),
        .external_clock_select (external_clock_select),
        .master_clk_ff         (master_clk)
    );

    // Input structure keeps tracking the master clock during hard reset
    always @(posedge aclk) begin
        if (!aresetn) begin
            mclk_d_ff <= 1'b0;
        end else begin
            mclk_d_ff <= master_clk;
        end
    end

    // No edge is distributed while the part is held in reset
    assign mclk_rise = master_clk & ~mclk_d_ff & rst_n;

    // ****************************************
    // Dividers
    // ****************************************
    reg  [2:0]  pre_cnt_ff;
    reg  [1:0]  smp_cnt_ff;
    reg  [11:0] dec_cnt_ff;
    reg  [11:0] half_cnt_ff;
    reg         aclk_lvl_ff;
    wire [2:0]  pre_last;
    wire        analog_clock_tick;
    wire        sample_clock_tick;
    wire        data_rate_clock_tick;

    // Prescale 1, 2, 4, 8 by code 00 to 11
    assign pre_last   = (3'h1 << prescale_sel) - 3'h1;
    assign analog_clock_tick = mclk_rise & (pre_cnt_ff == pre_last);
    assign sample_clock_tick = analog_clock_tick & (smp_cnt_ff == `ACR_SAMPLE_DIV - 3'h1);
    assign data_rate_clock_tick = sample_clock_tick & (dec_cnt_ff == osr_last(oversampling_field));

    // Counters start from zero after release, no stale phase
    always @(posedge aclk) begin
        if (!rst_n) begin
            pre_cnt_ff  <= 3'h0;
            smp_cnt_ff  <= 2'h0;
            dec_cnt_ff  <= 12'h000;
            aclk_lvl_ff <= 1'b0;
        end else begin
            if (mclk_rise) begin
                pre_cnt_ff <= analog_clock_tick ? 3'h0 : pre_cnt_ff + 3'h1;
            end
            if (analog_clock_tick) begin
                smp_cnt_ff  <= smp_cnt_ff + 2'h1;
                aclk_lvl_ff <= ~aclk_lvl_ff;
            end
            if (sample_clock_tick) begin
                dec_cnt_ff <= data_rate_clock_tick ? 12'h000 : dec_cnt_ff + 12'h001;
            end
        end
    end

    assign analog_clock = aclk_lvl_ff;

    // ****************************************
    // Done strobe, half a sample period low
    // ****************************************
    // Counts master clock edges; half sample period is 2 x prescale edges
    always @(posedge aclk) begin
        if (!rst_n) begin
            conversion_done_strobe_n_ff <= 1'b1;
            half_cnt_ff                 <= 12'h000;
        end else if (data_rate_clock_tick) begin
            conversion_done_strobe_n_ff <= 1'b0;
            half_cnt_ff                 <= 12'h000;
        end else if (!conversion_done_strobe_n_ff && mclk_rise) begin
            if (half_cnt_ff == {8'h00, pre_last, 1'b1}) begin
                conversion_done_strobe_n_ff <= 1'b1;
            end
            half_cnt_ff <= half_cnt_ff + 12'h001;
        end
    end

    // ****************************************
    // Sample capture and trimmed result
    // ****************************************
    reg  [23:0] sample_ff;
    wire [23:0] trimmed;

    // One modulator sample each sample period
    always @(posedge aclk) begin
        if (!rst_n) begin
            sample_ff <= 24'h000000;
        end else if (sample_clock_tick) begin
            sample_ff <= modulator_sample;
        end
    end

    acr_trim #(.W(`ACR_TRIM_W)) u_trim (
        .sample      (sample_ff),
        .offset_trim (channel_offset_trim[chan_sel]),
        .gain_trim   (channel_gain_trim[chan_sel]),
        .corrected   (trimmed)
    );

    always @(posedge aclk) begin
        if (!rst_n) begin
            result_ff <= 24'h000000;
        end else if (data_rate_clock_tick) begin
            result_ff <= trimmed;
        end
    end

    // ****************************************
    // AXI4-Lite slave
    // ****************************************
    reg        aw_hold_ff;
    reg        w_hold_ff;
    reg [11:0] aw_addr_ff;
    reg [31:0] w_data_ff;
    reg [3:0]  w_strb_ff;
    wire       wr_go;
    wire       rd_go;
    reg [31:0] rd_word;
    reg        rd_hit;
    reg        wr_hit;
    integer    k;
    wire [2:0]  wr_chan;
    wire [31:0] trim_merged;

    // Bus refused while in hard reset
    assign s_axi_awready = rst_n & ~aw_hold_ff & ~s_axi_bvalid;
    assign s_axi_wready  = rst_n & ~w_hold_ff & ~s_axi_bvalid;
    assign s_axi_arready = rst_n & ~s_axi_rvalid;
    assign wr_go = aw_hold_ff & w_hold_ff;
    assign rd_go = s_axi_arvalid & s_axi_arready;
    assign wr_chan = trim_chan(aw_addr_ff);
    // Old word of whichever trim is addressed, merged with the write lanes
    assign trim_merged = wmerge(aw_addr_ff[2] ? {8'h00, channel_gain_trim[wr_chan]} :
                                {8'h00, channel_offset_trim[wr_chan]}, w_data_ff, w_strb_ff);

    // Read decode
    always @* begin
        rd_word = 32'h00000000;
        rd_hit  = 1'b1;
        if (s_axi_araddr == `ACR_OFF_CONFIG) begin
            rd_word = config_ff;
        end else if (s_axi_araddr == `ACR_OFF_STATUS) begin
            rd_word = {29'h0, smp_cnt_ff, ~conversion_done_strobe_n_ff};
        end else if (s_axi_araddr == `ACR_OFF_IRQ_STAT) begin
            rd_word = {29'h0, irq_stat_ff};
        end else if (s_axi_araddr == `ACR_OFF_IRQ_MASK) begin
            rd_word = {29'h0, irq_mask_ff};
        end else if (s_axi_araddr == `ACR_OFF_SAMPLE) begin
            rd_word = {8'h00, sample_ff};
        end else if (s_axi_araddr == `ACR_OFF_RESULT) begin
            rd_word = {8'h00, result_ff};
        end else if (s_axi_araddr >= `ACR_OFF_TRIM_BASE &&
                     s_axi_araddr <= `ACR_OFF_TRIM_LAST) begin
            // Offset at +0, gain at +4 of each 8-byte channel pair
            rd_word = s_axi_araddr[2] ?
                {8'h00, channel_gain_trim[trim_chan(s_axi_araddr)]} :
                {8'h00, channel_offset_trim[trim_chan(s_axi_araddr)]};
        end else begin
            rd_hit = 1'b0;
        end
    end

    // Write decode validity
    always @* begin
        wr_hit = 1'b0;
        if (aw_addr_ff == `ACR_OFF_CONFIG || aw_addr_ff == `ACR_OFF_IRQ_STAT ||
            aw_addr_ff == `ACR_OFF_IRQ_MASK) begin
            wr_hit = 1'b1;
        end else if (aw_addr_ff >= `ACR_OFF_TRIM_BASE && aw_addr_ff <= `ACR_OFF_TRIM_LAST) begin
            wr_hit = 1'b1;
        end
    end

    // Channel handshakes, registers and interrupt status
    always @(posedge aclk) begin
        if (!rst_n) begin
            aw_hold_ff   <= 1'b0;
            w_hold_ff    <= 1'b0;
            aw_addr_ff   <= 12'h000;
            w_data_ff    <= 32'h00000000;
            w_strb_ff    <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `ACR_RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp  <= `ACR_RESP_OKAY;
            s_axi_rdata  <= 32'h00000000;
            config_ff    <= `ACR_CFG_RESET;
            irq_stat_ff  <= 3'h0;
            irq_mask_ff  <= 3'h0;
            for (k = 0; k < NCH; k = k + 1) begin
                channel_offset_trim[k] <= 24'h000000;
                channel_gain_trim[k]   <= 24'h000000;
            end
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_ff <= 1'b1;
                aw_addr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_ff <= 1'b1;
                w_data_ff <= s_axi_wdata;
                w_strb_ff <= s_axi_wstrb;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            // Event sets win over a software clear in the same cycle
            irq_stat_ff <= irq_stat_ff | {1'b0, sample_clock_tick, data_rate_clock_tick};
            if (wr_go) begin
                aw_hold_ff   <= 1'b0;
                w_hold_ff    <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? `ACR_RESP_OKAY : `ACR_RESP_SLVERR;
                if (aw_addr_ff == `ACR_OFF_CONFIG) begin
                    config_ff <= wmerge(config_ff, w_data_ff, w_strb_ff);
                end else if (aw_addr_ff == `ACR_OFF_IRQ_STAT && w_strb_ff[0]) begin
                    irq_stat_ff <= (irq_stat_ff & ~w_data_ff[2:0])
                                   | {1'b0, sample_clock_tick, data_rate_clock_tick};
                end else if (aw_addr_ff == `ACR_OFF_IRQ_MASK && w_strb_ff[0]) begin
                    irq_mask_ff <= w_data_ff[2:0];
                end else if (wr_hit && aw_addr_ff[2]) begin
                    channel_gain_trim[wr_chan] <= trim_merged[23:0];
                end else if (wr_hit) begin
                    channel_offset_trim[wr_chan] <= trim_merged[23:0];
                end
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
            if (rd_go) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_word;
                s_axi_rresp  <= rd_hit ? `ACR_RESP_OKAY : `ACR_RESP_SLVERR;
            end
        end
    end

    // Level interrupt while any unmasked status bit is set
    assign irq = |(irq_stat_ff & irq_mask_ff);

endmodule

`default_nettype wire

/* tb/acr_assertions.sv */
// Purpose: port level checks of the clock, rate and reset block
// Assumes: master clock slower than a quarter of aclk
// Notes:   bound into every acr_top instance
`timescale 1ns/1ps
`default_nettype none

module acr_assertions (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        hard_reset_n,
    input wire logic        conversion_done_strobe_n_ff,
    input wire logic        analog_clock,
    input wire logic        irq,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata
);
    // ****************************************
    // Checks
    // ****************************************
    // Bus checks pause in hard reset, which may cut a transfer short
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn || !hard_reset_n);

    // Five samples low lets the pin synchroniser settle
    sequence s_hard_held;
        !hard_reset_n [*5];
    endsequence
    sequence s_both_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence

    a_write_answer: assert property (s_both_taken |-> ##2 s_axi_bvalid)
        else $error("write response late");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response late");
    a_resp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read response dropped");
    a_read_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while busy");
    a_write_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while busy");
    a_hard_refuses: assert property (@(posedge aclk) disable iff (!aresetn)
        s_hard_held |-> !s_axi_awready && !s_axi_wready && !s_axi_arready)
        else $error("bus open in hard reset");
    a_hard_defaults: assert property (@(posedge aclk) disable iff (!aresetn)
        s_hard_held |-> conversion_done_strobe_n_ff && !irq)
        else $error("outputs not idle in hard reset");
    a_clock_stops: assert property (@(posedge aclk) disable iff (!aresetn)
        s_hard_held |=> $stable(analog_clock))
        else $error("analog clock runs in hard reset");
    a_done_width: assert property ($fell(conversion_done_strobe_n_ff) |-> !conversion_done_strobe_n_ff [*4])
        else $error("done pulse too short");
    a_done_spacing: assert property ($rose(conversion_done_strobe_n_ff) |-> conversion_done_strobe_n_ff [*8])
        else $error("done pulses too close");
endmodule

bind acr_top acr_assertions i_chk (
    .aclk, .aresetn, .hard_reset_n, .conversion_done_strobe_n_ff, .analog_clock, .irq,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
    .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata
);
`default_nettype wire

/* tb/acr_host_model.sv */
// Purpose: host side, crystal, clock pin and hard reset pin
// Assumes: both clock sources free running, phase unrelated to aclk
// Notes:   hard reset is pulsed by the bench through hold_reset
`timescale 1ns/1ps
`default_nettype none

module acr_host_model #(
    parameter int XTAL_HALF = 75,
    parameter int PIN_HALF  = 100
) (
    input  wire logic aclk,
    output var logic  crystal_clk,
    output var logic  crystal_or_clock_pin,
    output var logic  hard_reset_n
);
    // Clocks keep running through hard reset; offset avoids aclk edges
    initial begin
        crystal_clk = 1'b0;
        #7;
        forever #(XTAL_HALF) crystal_clk = ~crystal_clk;
    end
    initial begin
        crystal_or_clock_pin = 1'b0;
        #7;
        forever #(PIN_HALF) crystal_or_clock_pin = ~crystal_or_clock_pin;
    end
    initial hard_reset_n = 1'b1;

    // Hold the reset pin low for n bus cycles
    task automatic hold_reset(input int n);
        hard_reset_n <= 1'b0;
        repeat (n) @(posedge aclk);
        hard_reset_n <= 1'b1;
    endtask
endmodule
`default_nettype wire

/* tb/acr_top_tb.sv */
// Purpose: self-checking bench of the clock, rate and reset block
// Assumes: master clock 6 aclk cycles, clock pin 8 cycles
// Notes:   rates are measured in aclk cycles on the done strobe
`timescale 1ns/1ps
`default_nettype none
`include "acr_map.vh"

module acr_top_tb;
    // ****************************************
    // Signals and instances
    // ****************************************
    localparam int MP = 6;
    logic        aclk    = 1'b0;
    logic        aresetn = 1'b0;
    logic [23:0] smp     = 24'h000000;
    logic [11:0] awaddr  = 12'h000;
    logic [31:0] wdata   = 32'h00000000;
    logic [11:0] araddr  = 12'h000;
    logic        awvalid = 1'b0;
    logic        wvalid  = 1'b0;
    logic        bready  = 1'b0;
    logic        arvalid = 1'b0;
    logic        rready  = 1'b0;
    wire  [1:0]  bresp, rresp;
    wire  [31:0] rdata;
    wire  [23:0] result;
    wire         awready, wready, bvalid, arready, rvalid;
    wire         done_n, ana, irq, xtal, pin, hrst_n;
    logic [31:0] d;
    logic [1:0]  r;
    int          n_fail  = 0;
    int          n_tests = 0;
    int          i, n, lo, per;

    acr_host_model i_host (.aclk(aclk), .crystal_clk(xtal), .crystal_or_clock_pin(pin),
        .hard_reset_n(hrst_n));
    acr_top i_dut (.aclk(aclk), .aresetn(aresetn), .hard_reset_n(hrst_n),
        .crystal_clk(xtal), .crystal_or_clock_pin(pin), .modulator_sample(smp),
        .conversion_done_strobe_n_ff(done_n), .result_ff(result), .analog_clock(ana),
        .irq(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready));

    // 40 MHz bus clock
    initial begin
        forever #12.5 aclk = ~aclk;
    end

    // ****************************************
    // Tasks
    // ****************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Handshakes are judged at the falling edge, acted on at the next rise
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        int t;
        logic ah, wh, bh;
        awaddr  <= a;
        wdata   <= v;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        t = 0;
        do begin
            @(negedge aclk);
            ah = (awvalid && awready) === 1'b1;
            wh = (wvalid && wready) === 1'b1;
            bh = bvalid === 1'b1;
            r  = bresp;
            @(posedge aclk);
            if (ah) awvalid <= 1'b0;
            if (wh) wvalid <= 1'b0;
            t++;
        end while (!bh && t < 99);
        bready <= 1'b0;
        if (!bh) n_fail++;
        @(posedge aclk);
    endtask

    task automatic rd(input logic [11:0] a);
        int t;
        logic ah, bh;
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        t = 0;
        do begin
            @(negedge aclk);
            ah = (arvalid && arready) === 1'b1;
            bh = rvalid === 1'b1;
            d  = rdata;
            r  = rresp;
            @(posedge aclk);
            if (ah) arvalid <= 1'b0;
            t++;
        end while (!bh && t < 99);
        rready <= 1'b0;
        if (!bh) n_fail++;
        @(posedge aclk);
    endtask

    // Count cycles until the done strobe shows level v
    task automatic lvl(input logic v, inout int c);
        while (done_n !== v && c < 40000) begin
            @(negedge aclk);
            c++;
        end
    endtask

    // Low width and period of the first whole strobe cycle
    task automatic meas;
        n = 0;
        lvl(1'b1, n);
        lvl(1'b0, n);
        lo = 0;
        lvl(1'b1, lo);
        per = lo;
        lvl(1'b0, per);
        @(posedge aclk);
    endtask

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // ****************************************
    // Tests
    // ****************************************
    // Main sequence; the reset release is the only change on that edge
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(`ACR_OFF_CONFIG);
        chk(d, `ACR_CFG_RESET);
        rd(`ACR_OFF_IRQ_MASK);
        chk(d, 32'h0);
        rd(12'h020);
        chk(r, `ACR_RESP_SLVERR);
        wr(12'h030, 32'h1);
        chk(r, `ACR_RESP_SLVERR);
        $display("end of test: defaults");
        // Channel two trimmed, channel zero left plain
        wr(12'h050, 32'h10);
        wr(12'h054, 32'h400000);
        wr(`ACR_OFF_CONFIG, 32'h2000);
        smp <= 24'h000100;
        meas;
        chk(result, 32'h198);
        wr(`ACR_OFF_CONFIG, 32'h0);
        meas;
        chk(result, 32'h100);
        $display("end of test: trims");
        wr(`ACR_OFF_IRQ_MASK, 32'h1);
        meas;
        chk(irq, 1'b1);
        wr(`ACR_OFF_IRQ_STAT, 32'h3);
        chk(irq, 1'b0);
        wr(`ACR_OFF_IRQ_MASK, 32'h0);
        meas;
        chk(irq, 1'b0);
        rd(`ACR_OFF_IRQ_STAT);
        chk(d[0], 1'b1);
        $display("end of test: interrupt");
        // Prescale codes at ratio 32, then ratio codes 1 and 2
        for (i = 0; i < 6; i++) begin
            wr(`ACR_OFF_CONFIG, 32'(i < 4 ? i << 4 : i - 3));
            meas;
            chk(per, (128 * MP) << (i < 4 ? i : i - 3));
            chk(lo, (2 * MP) << (i < 4 ? i : 0));
        end
        $display("end of test: rates");
        wr(`ACR_OFF_CONFIG, 32'h100);
        meas;
        chk(per, 128 * 8);
        chk(lo, 2 * 8);
        $display("end of test: clock pin");
        fork
            i_host.hold_reset(30);
            begin
                repeat (10) @(negedge aclk);
                chk(arready, 1'b0);
                chk(done_n, 1'b1);
                chk(irq, 1'b0);
                chk(ana, 1'b0);
            end
        join
        // Defaults return: crystal, prescale 1, ratio 256
        n = 0;
        lvl(1'b0, n);
        chk(n >= 1023 * MP && n < 1024 * MP + 24, 1'b1);
        @(posedge aclk);
        rd(`ACR_OFF_CONFIG);
        chk(d, `ACR_CFG_RESET);
        $display("end of test: hard reset");
        conclude;
    end

    // Cuts a hang short, well past the expected run length
    initial begin
        #(25 * 90000);
        n_fail++;
        conclude;
    end
endmodule
`default_nettype wire
